// ### inc/setpoint_pkg.sv
`default_nettype none
package setpoint_pkg;

    // ------------------------------------------------------------
    // temperature format: signed, 0.1 K per step
    // ------------------------------------------------------------
    typedef logic signed [15:0] temp_t;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_MODE = 8'h04;
    localparam logic [7:0] OFF_BASE = 8'h08;
    localparam logic [7:0] OFF_OFFSET = 8'h0C;
    localparam logic [7:0] OFF_ROTARY = 8'h10;
    localparam logic [7:0] OFF_BLIM = 8'h14;
    localparam logic [7:0] OFF_PROT = 8'h18;
    localparam logic [7:0] OFF_RED = 8'h1C;
    localparam logic [7:0] OFF_DZ = 8'h20;
    localparam logic [7:0] OFF_LOAD = 8'h24;
    localparam logic [7:0] OFF_TEMP = 8'h28;
    localparam logic [7:0] OFF_STAT = 8'h2C;

    // ------------------------------------------------------------
    // control register bit positions
    // ------------------------------------------------------------
    localparam int CTRL_ROT_OFS = 0;
    localparam int CTRL_AUTO = 1;
    localparam int CTRL_COOL = 2;
    localparam int CTRL_WIN = 3;
    localparam int CTRL_RESTART = 4;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [3:0] CTRL_RST = 4'h1;
    localparam temp_t BASE_RST = 16'sh00D2;
    localparam temp_t BMIN_RST = 16'sh0096;
    localparam temp_t BMAX_RST = 16'sh012C;
    localparam temp_t FROST_RST = 16'sh0046;
    localparam temp_t HEAT_RST = 16'sh015E;
    localparam temp_t MAXOFF_RST = 16'sh0014;
    localparam temp_t DZ_RST = 16'sh0014;
    localparam logic [7:0] RED_RST = 8'h14;
    localparam temp_t TEMP_RST = 16'sh00C8;
    // largest reduction or increase: 8 K
    localparam logic [7:0] MAX_RED = 8'h50;

    // ------------------------------------------------------------
    // modes and command sources
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_COMFORT = 2'b00,
        MODE_STANDBY = 2'b01,
        MODE_NIGHT = 2'b10,
        MODE_PROT = 2'b11
    } opmode_e;

    typedef enum logic [1:0] {
        SRC_OPERATOR = 2'b00,
        SRC_OBJECT = 2'b01,
        SRC_PROGRAM = 2'b10,
        SRC_SCENE = 2'b11
    } src_e;

    // ------------------------------------------------------------
    // configuration carried as one struct
    // ------------------------------------------------------------
    typedef struct packed {
        temp_t bmax;
        temp_t bmin;
        temp_t heat;
        temp_t frost;
        temp_t maxoff;
        temp_t dz;
        logic [7:0] inc_nt;
        logic [7:0] inc_sb;
        logic [7:0] red_nt;
        logic [7:0] red_sb;
    } cfg_s;

    localparam cfg_s CFG_RST = '{BMAX_RST, BMIN_RST, HEAT_RST, FROST_RST,
        MAXOFF_RST, DZ_RST, RED_RST, RED_RST, RED_RST, RED_RST};

endpackage
`default_nettype wire

// ### hdl/sat_clamp.sv
`default_nettype none
module sat_clamp #(
    parameter int W = 18
) (
    input wire logic signed [W-1:0] x, // value to limit
    input wire logic signed [W-1:0] lo, // lower bound
    input wire logic signed [W-1:0] hi, // upper bound
    output logic signed [W-1:0] y // limited value
);

    // ------------------------------------------------------------
    // lower bound first, upper bound wins if bounds cross
    // ------------------------------------------------------------
    logic signed [W-1:0] up;
    assign up = (x < lo) ? lo : x;
    assign y = (up > hi) ? hi : up;

endmodule
`default_nettype wire

// ### hdl/setpoint_calc.sv
// What this block does
// - cooling standby: base+offset+deadzone+standby increase
// - offset from offset object or rotary
// - offset limited to plus/minus maximum
// - offset always relative to base setpoint
// - new offset replaces old, not added
// - base is comfort value and reduction reference
// - base loaded from config; writes need manual-offset
// - restart after supply return keeps base
// - control to setpoint after all adjustments
// - base from object clamped to min/max
// - setpoint kept within frost/heat limits
// - cooling raises setpoint by dead zone
// - frost mode uses frost protection setpoint
// - heat protection mode uses heat setpoint
// - heat/cool switch automatic or commanded
// - mode from operator, object, program, scene
// - reductions and increases at most 8 K
// - heating standby/night: base+offset minus reduction
// - cooling comfort: base+offset+dead zone
// - window frost overrides; else last command wins
//
// Our own choices: the APB slave port and the placing of the registers.
`default_nettype none
module setpoint_calc
    import setpoint_pkg::*;
(
    input wire logic pclk, // bus clock, 100 MHz
    input wire logic presetn, // asynchronous reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    output logic signed [15:0] setpoint, // current setpoint, 0.1 K
    output logic cooling, // 1 while cooling
    output logic [1:0] mode // effective operating mode
);

    localparam int W = 18;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [3:0] ctrl_q;
    opmode_e mode_q;
    src_e src_q;
    opmode_e mode_out_q;
    temp_t base_q;
    temp_t off_q;
    temp_t temp_q;
    temp_t sp_q;
    cfg_s cfg_q;
    logic cool_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic acc, wr, mapped, setup;
    logic wr_ctrl, wr_mode, wr_base, wr_off, wr_rot, wr_blim;
    logic wr_prot, wr_red, wr_dz, wr_load, wr_temp;
    assign setup = psel & ~penable;
    assign acc = psel & penable & pready_q;
    assign wr = acc & pwrite & ~pslverr_q;
    assign mapped = paddr inside {OFF_CTRL, OFF_MODE, OFF_BASE,
        OFF_OFFSET, OFF_ROTARY, OFF_BLIM, OFF_PROT, OFF_RED, OFF_DZ,
        OFF_LOAD, OFF_TEMP, OFF_STAT};
    assign wr_ctrl = wr & (paddr == OFF_CTRL);
    assign wr_mode = wr & (paddr == OFF_MODE);
    assign wr_base = wr & (paddr == OFF_BASE);
    assign wr_off = wr & (paddr == OFF_OFFSET);
    assign wr_rot = wr & (paddr == OFF_ROTARY);
    assign wr_blim = wr & (paddr == OFF_BLIM);
    assign wr_prot = wr & (paddr == OFF_PROT);
    assign wr_red = wr & (paddr == OFF_RED);
    assign wr_dz = wr & (paddr == OFF_DZ);
    assign wr_load = wr & (paddr == OFF_LOAD);
    assign wr_temp = wr & (paddr == OFF_TEMP);

    // ------------------------------------------------------------
    // control bits and write qualifiers
    // ------------------------------------------------------------
    logic rot_ofs, restart, base_we, off_we;
    assign rot_ofs = ctrl_q[CTRL_ROT_OFS];
    assign restart = wr_ctrl & pwdata[CTRL_RESTART];
    // base object only while rotary gives offsets
    assign base_we = (wr_base & rot_ofs) | (wr_rot & ~rot_ofs) | wr_load;
    // both offset sources land in the same register
    assign off_we = wr_off | (wr_rot & rot_ofs);

    // ------------------------------------------------------------
    // sign extension to the working width
    // ------------------------------------------------------------
    logic signed [W-1:0] wd_x, bmin_x, bmax_x, moff_x, nmoff_x;
    logic signed [W-1:0] base_x, off_x, frost_x, heat_x, dz_x, temp_x;
    assign wd_x = {{2{pwdata[15]}}, pwdata[15:0]};
    assign bmin_x = {{2{cfg_q.bmin[15]}}, cfg_q.bmin};
    assign bmax_x = {{2{cfg_q.bmax[15]}}, cfg_q.bmax};
    assign moff_x = {{2{cfg_q.maxoff[15]}}, cfg_q.maxoff};
    assign nmoff_x = 18'sh00000 - moff_x;
    assign base_x = {{2{base_q[15]}}, base_q};
    assign off_x = {{2{off_q[15]}}, off_q};
    assign frost_x = {{2{cfg_q.frost[15]}}, cfg_q.frost};
    assign heat_x = {{2{cfg_q.heat[15]}}, cfg_q.heat};
    assign dz_x = {{2{cfg_q.dz[15]}}, cfg_q.dz};
    assign temp_x = {{2{temp_q[15]}}, temp_q};

    // ------------------------------------------------------------
    // limiters
    // ------------------------------------------------------------
    logic signed [W-1:0] base_new, off_new, off_eff, sp_raw, sp_safe;
    // base written from outside stays inside its valid range
    sat_clamp #(.W(W)) u_base (
        .x(wd_x), .lo(bmin_x), .hi(bmax_x), .y(base_new));
    // offset written is limited symmetrically
    sat_clamp #(.W(W)) u_off (
        .x(wd_x), .lo(nmoff_x), .hi(moff_x), .y(off_new));
    // stored offset limited again if the maximum shrinks
    sat_clamp #(.W(W)) u_use (
        .x(off_x), .lo(nmoff_x), .hi(moff_x), .y(off_eff));
    // safety limits on the final value
    sat_clamp #(.W(W)) u_safe (
        .x(sp_raw), .lo(frost_x), .hi(heat_x), .y(sp_safe));

    // ------------------------------------------------------------
    // reductions and increases capped at 8 K
    // ------------------------------------------------------------
    logic [31:0] red_cap;
    for (genvar i = 0; i < 4; i++) begin : g_red
        assign red_cap[8*i +: 8] = (pwdata[8*i +: 8] > MAX_RED) ?
            MAX_RED : pwdata[8*i +: 8];
    end

    // ------------------------------------------------------------
    // effective mode: window frost beats every source
    // ------------------------------------------------------------
    opmode_e mode_eff;
    assign mode_eff = ctrl_q[CTRL_WIN] ? MODE_PROT : mode_q;

    // ------------------------------------------------------------
    // setpoint arithmetic, all exact integers
    // ------------------------------------------------------------
    logic signed [W-1:0] sum_x, adj_x, prot_x, red_sb_x, red_nt_x;
    logic signed [W-1:0] inc_sb_x, inc_nt_x, cool_sp_x;
    // offset added to the base, never to the current setpoint
    assign sum_x = base_x + off_eff;
    assign cool_sp_x = sum_x + dz_x;
    assign red_sb_x = {10'h000, cfg_q.red_sb};
    assign red_nt_x = {10'h000, cfg_q.red_nt};
    assign inc_sb_x = {10'h000, cfg_q.inc_sb};
    assign inc_nt_x = {10'h000, cfg_q.inc_nt};
    assign prot_x = cool_q ? heat_x : frost_x;

    // mode-dependent adjustment relative to the base
    always_comb begin
        unique case (mode_eff)
            MODE_COMFORT: adj_x = cool_q ? dz_x : 18'sh00000;
            MODE_STANDBY: adj_x = cool_q ? dz_x + inc_sb_x
                                         : 18'sh00000 - red_sb_x;
            MODE_NIGHT: adj_x = cool_q ? dz_x + inc_nt_x
                                       : 18'sh00000 - red_nt_x;
            MODE_PROT: adj_x = 18'sh00000;
        endcase
    end

    // protection modes substitute their own value
    assign sp_raw = (mode_eff == MODE_PROT) ? prot_x : sum_x + adj_x;

    // ------------------------------------------------------------
    // heating or cooling choice
    // ------------------------------------------------------------
    logic cool_d;
    // automatic mode keeps state inside the dead zone
    assign cool_d = ~ctrl_q[CTRL_AUTO] ? ctrl_q[CTRL_COOL] :
        (temp_x > cool_sp_x) ? 1'b1 :
        (temp_x < sum_x) ? 1'b0 : cool_q;

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    logic [31:0] rd_d;
    logic [31:0] stat_w;
    assign stat_w = {11'h000, src_q, cool_q, mode_out_q, sp_q};
    assign rd_d =
        (paddr == OFF_CTRL) ? {28'h0000000, ctrl_q} :
        (paddr == OFF_MODE) ? {28'h0000000, src_q, mode_q} :
        (paddr == OFF_BASE) ? {16'h0000, base_q} :
        (paddr == OFF_OFFSET) ? {16'h0000, off_q} :
        (paddr == OFF_BLIM) ? {cfg_q.bmax, cfg_q.bmin} :
        (paddr == OFF_PROT) ? {cfg_q.heat, cfg_q.frost} :
        (paddr == OFF_RED) ? {cfg_q.inc_nt, cfg_q.inc_sb,
                              cfg_q.red_nt, cfg_q.red_sb} :
        (paddr == OFF_DZ) ? {cfg_q.maxoff, cfg_q.dz} :
        (paddr == OFF_TEMP) ? {16'h0000, temp_q} :
        (paddr == OFF_STAT) ? stat_w : 32'h00000000;

    // ------------------------------------------------------------
    // apb handshake: ready in the cycle after setup
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup & ~mapped;
            prdata_q <= (setup & ~pwrite) ? rd_d : 32'h00000000;
        end
    end

    // ------------------------------------------------------------
    // control, mode and configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RST;
            cfg_q <= CFG_RST;
            temp_q <= TEMP_RST;
        end else begin
            if (wr_ctrl) ctrl_q <= pwdata[3:0];
            if (wr_blim) {cfg_q.bmax, cfg_q.bmin} <= pwdata;
            if (wr_prot) {cfg_q.heat, cfg_q.frost} <= pwdata;
            if (wr_red) begin
                {cfg_q.inc_nt, cfg_q.inc_sb} <= red_cap[31:16];
                {cfg_q.red_nt, cfg_q.red_sb} <= red_cap[15:0];
            end
            if (wr_dz) {cfg_q.maxoff, cfg_q.dz} <= pwdata;
            if (wr_temp) temp_q <= pwdata[15:0];
        end
    end

    // last mode command wins, whatever its source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= MODE_COMFORT;
            src_q <= SRC_OPERATOR;
        end else if (restart) begin
            mode_q <= MODE_COMFORT;
            src_q <= SRC_OPERATOR;
        end else if (wr_mode) begin
            mode_q <= opmode_e'(pwdata[1:0]);
            src_q <= src_e'(pwdata[3:2]);
        end
    end

    // base survives a restart; only reset or a load, base or rotary write changes it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_q <= BASE_RST;
        end else if (base_we) begin
            base_q <= base_new[15:0];
        end
    end

    // a new offset replaces the old one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            off_q <= 16'sh0000;
        end else if (restart) begin
            off_q <= 16'sh0000;
        end else if (off_we) begin
            off_q <= off_new[15:0];
        end
    end

    // result registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cool_q <= 1'b0;
            sp_q <= BASE_RST;
            mode_out_q <= MODE_COMFORT;
        end else begin
            cool_q <= restart ? 1'b0 : cool_d;
            sp_q <= sp_safe[15:0];
            mode_out_q <= mode_eff;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign setpoint = sp_q;
    assign cooling = cool_q;
    assign mode = mode_out_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_base_locked;
        @(posedge pclk) disable iff (!presetn)
        (wr_base && !rot_ofs) |=> $stable(base_q);
    endproperty
    a_base_locked: assert property (p_base_locked)
        else $error("base object write taken in base-setpoint mode");

    property p_base_range;
        @(posedge pclk) disable iff (!presetn)
        (wr_base && rot_ofs && cfg_q.bmin <= cfg_q.bmax) |=>
            (base_q >= $past(cfg_q.bmin) && base_q <= $past(cfg_q.bmax));
    endproperty
    a_base_range: assert property (p_base_range)
        else $error("base setpoint outside valid limits");

    property p_off_limit;
        @(posedge pclk) disable iff (!presetn)
        (cfg_q.maxoff >= 16'sh0000) |->
            (off_eff <= moff_x && off_eff >= nmoff_x);
    endproperty
    a_off_limit: assert property (p_off_limit)
        else $error("applied offset beyond maximum");

    property p_restart_keeps_base;
        @(posedge pclk) disable iff (!presetn)
        (restart && !base_we) |=> $stable(base_q) ##1 $stable(base_q);
    endproperty
    a_restart_keeps_base: assert property (p_restart_keeps_base)
        else $error("base setpoint lost over restart");

    property p_window_frost;
        @(posedge pclk) disable iff (!presetn)
        ctrl_q[CTRL_WIN] |=> (mode == MODE_PROT);
    endproperty
    a_window_frost: assert property (p_window_frost)
        else $error("window open but mode not protection");

    property p_frost_sub;
        @(posedge pclk) disable iff (!presetn)
        (mode_eff == MODE_PROT && !cool_q && cfg_q.frost <= cfg_q.heat)
            |=> (setpoint == $past(cfg_q.frost));
    endproperty
    a_frost_sub: assert property (p_frost_sub)
        else $error("frost protection setpoint not used");

    property p_heat_sub;
        @(posedge pclk) disable iff (!presetn)
        (mode_eff == MODE_PROT && cool_q && cfg_q.frost <= cfg_q.heat)
            |=> (setpoint == $past(cfg_q.heat));
    endproperty
    a_heat_sub: assert property (p_heat_sub)
        else $error("heat protection setpoint not used");

    property p_safety;
        @(posedge pclk) disable iff (!presetn)
        (cfg_q.frost <= cfg_q.heat) |=>
            (setpoint >= $past(cfg_q.frost) && setpoint <= $past(cfg_q.heat));
    endproperty
    a_safety: assert property (p_safety)
        else $error("setpoint outside safety limits");

    property p_red_cap;
        @(posedge pclk) disable iff (!presetn)
        wr_red |=> (cfg_q.red_sb <= MAX_RED && cfg_q.inc_nt <= MAX_RED);
    endproperty
    a_red_cap: assert property (p_red_cap)
        else $error("reduction above 8 K stored");

    property p_offset_replace;
        @(posedge pclk) disable iff (!presetn)
        (wr_off && !restart) |=> (off_q == $past(off_new[15:0]));
    endproperty
    a_offset_replace: assert property (p_offset_replace)
        else $error("offset not replaced by received value");
endmodule
`default_nettype wire

// ### bench/apb_host.sv
`default_nettype none
module apb_host (
    input wire logic pclk, // bus clock
    input wire logic pready, // slave ready
    input wire logic pslverr, // slave error
    input wire logic [31:0] prdata, // read data
    output logic psel, // select
    output logic penable, // access phase
    output logic pwrite, // direction
    output logic [7:0] paddr, // byte address
    output logic [31:0] pwdata // write data
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // one transfer; ok stays low if the slave never answers
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e,
        output logic ok);
        ok = 1'b0;
        q = 32'h0;
        e = 1'b0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (int i = 0; i < 16 && !ok; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                ok = 1'b1;
                q = prdata;
                e = pslverr;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines do not keep the old value
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

// ### bench/setpoint_calc_tb.sv
`default_nettype none
module setpoint_calc_tb
    import setpoint_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------
    // signals and expected values
    // ------------------------------------------------
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic cooling, re, ok;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rq;
    logic signed [15:0] setpoint;
    logic [1:0] mode;
    int fail_count = 0;
    int checks_done = 0;
    // heating then cooling: comfort, standby, night, protection
    temp_t exp_sp [8] = '{16'sh00C8, 16'sh00B4, 16'sh00B4, 16'sh0046,
        16'sh00DC, 16'sh00F0, 16'sh00F0, 16'sh015E};

    setpoint_calc dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .setpoint(setpoint), .cooling(cooling),
        .mode(mode));

    apb_host host (.pclk(pclk), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    // 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ------------------------------------------------
    // helpers
    // ------------------------------------------------
    task automatic chk(input string n, input logic [31:0] s,
        input logic [31:0] x);
        checks_done++;
        if (s !== x) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, x, s);
        end
    endtask

    task automatic tally_and_finish();
        if (fail_count == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // transfer with a hang counted as a mismatch
    task automatic go(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        host.xfer(wr, a, d, rq, re, ok);
        if (!ok) begin
            fail_count++;
            tally_and_finish();
        end
    endtask

    task automatic w(input logic [7:0] a, input logic [31:0] d);
        go(1'b1, a, d);
    endtask

    task automatic r(input logic [7:0] a, input logic [31:0] x,
        input logic xe);
        go(1'b0, a, 32'h0);
        chk("prdata", rq, x);
        chk("pslverr", {31'h0, re}, {31'h0, xe});
    endtask

    // outputs follow within two edges of the store
    task automatic sp(input temp_t x);
        repeat (2) @(posedge pclk);
        #1;
        chk("setpoint", {16'h0000, setpoint}, {16'h0000, x});
    endtask

    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial begin
        presetn = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        sp(16'sh00D2);
        r(OFF_CTRL, 32'h1, 1'b0);
        w(OFF_OFFSET, 32'd10);
        sp(16'sh00DC);
        w(OFF_OFFSET, 32'd5);
        sp(16'sh00D7);
        w(OFF_OFFSET, 32'd50);
        sp(16'sh00E6);
        w(OFF_OFFSET, 32'hFFFF_FFCE);
        sp(16'sh00BE);
        r(OFF_OFFSET, 32'h0000_FFEC, 1'b0);
        w(OFF_ROTARY, 32'hFFFF_FFF6);
        sp(16'sh00C8);
        // lowering the maximum limits the stored offset on use
        w(OFF_DZ, 32'h0005_0014);
        sp(16'sh00CD);
        w(OFF_DZ, 32'h0014_0014);
        // each mode from the source of the same number, heating then cooling
        for (int i = 0; i < 8; i++) begin
            if (i % 4 == 0) begin
                w(OFF_CTRL, (i < 4) ? 32'h1 : 32'h5);
            end
            w(OFF_MODE, {28'h0, i[1:0], i[1:0]});
            sp(exp_sp[i]);
            chk("mode", {30'h0, mode}, {30'h0, i[1:0]});
            chk("cooling", {31'h0, cooling}, {31'h0, i[2]});
            r(OFF_STAT, {11'h0, i[1:0], i[2], i[1:0], exp_sp[i]},
                1'b0);
        end
        w(OFF_CTRL, 32'h9);
        w(OFF_MODE, 32'h1);
        sp(16'sh0046);
        chk("mode", {30'h0, mode}, 32'd3);
        w(OFF_CTRL, 32'h1);
        sp(16'sh00B4);
        w(OFF_RED, 32'h1414_14FF);
        sp(16'sh0078);
        r(OFF_RED, 32'h1414_1450, 1'b0);
        w(OFF_PROT, 32'h015E_0096);
        sp(16'sh0096);
        w(OFF_PROT, 32'h015E_0046);
        w(OFF_RED, 32'h1414_1414);
        w(OFF_MODE, 32'h0);
        w(OFF_BASE, 32'd400);
        sp(16'sh0122);
        w(OFF_BASE, 32'd0);
        sp(16'sh008C);
        // raised lower limit, then back to the old limits
        w(OFF_BLIM, 32'h012C_00A0);
        w(OFF_BASE, 32'd0);
        sp(16'sh0096);
        r(OFF_BLIM, 32'h012C_00A0, 1'b0);
        w(OFF_BLIM, 32'h012C_0096);
        w(OFF_BASE, 32'd0);
        w(OFF_CTRL, 32'h0);
        w(OFF_BASE, 32'd250);
        sp(16'sh008C);
        // rotary sets the base while it is not an offset source
        w(OFF_ROTARY, 32'd250);
        sp(16'sh00F0);
        r(OFF_OFFSET, 32'h0000_FFF6, 1'b0);
        w(OFF_LOAD, 32'd220);
        sp(16'sh00D2);
        w(OFF_CTRL, 32'h1);
        w(OFF_MODE, 32'h2);
        w(OFF_CTRL, 32'h11);
        sp(16'sh00DC);
        chk("mode", {30'h0, mode}, 32'd0);
        r(OFF_BASE, 32'h0000_00DC, 1'b0);
        w(OFF_TEMP, 32'd300);
        w(OFF_CTRL, 32'h3);
        sp(16'sh00F0);
        chk("cooling", {31'h0, cooling}, 32'd1);
        w(OFF_TEMP, 32'd100);
        sp(16'sh00DC);
        chk("cooling", {31'h0, cooling}, 32'd0);
        r(8'h30, 32'h0, 1'b1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
